// ===== verilog/sbs_regs.sv
`timescale 1ns/1ps
`include "sbs_defs.svh"
// Overview of operation
// - Supply source bits 7 and 6 latch LDO3 power-good and undervoltage flag rises.
// - Supply source bits 5 and 4 latch LDO2 power-good and undervoltage flag rises.
// - Supply source bits 3 and 2 latch 5V power-good and undervoltage flag rises.
// - Supply source bits 1 and 0 latch battery power-good and undervoltage flag rises.
// - Bus status bits 7..4: dominant, TxD-RxD short, RxD recessive, TxD dominant.
// - Bus status bits 3..0: low to supply, low to ground, high to ground, high to supply.
// - Thermal status bit 1 shows recovery below 140 degrees.
// - Thermal status bit 0 warns above 160 degrees; bits 7..2 read zero.
// - Summary bit 2 is set while any supply source bit is set.
module sbs_regs
  import sbs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire sbs_rail_s i_rail,
  input wire sbs_bus_s i_bus,
  input wire logic i_thermal_recovered,
  input wire logic i_thermal_warning,
  input wire sbs_req_s i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_supply_summary
);
  sbs_rail_s rail_s;
  sbs_bus_s bus_s;
  logic [1:0] therm_s;
  logic [7:0] rail_prev_r;
  logic [7:0] src_r;
  logic [7:0] src_nxt;
  logic [7:0] rise;
  logic [7:0] rdata_nxt;

  // Decode of a write to the supply source register
  function automatic logic is_src_wr(input sbs_req_s r);
    return r.wr && (r.addr == `SBS_ADDR_SUPPLY_IRQ);
  endfunction

  // Monitor inputs come from analog domain
  sbs_sync #(.WIDTH(8), .RESET_VAL(`SBS_RST_RAIL)) u_rail_sync
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_rail),
    .o_sync(rail_s)
  );
  sbs_sync #(.WIDTH(8), .RESET_VAL(`SBS_RST_BUS_FAULT)) u_bus_sync
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_bus),
    .o_sync(bus_s)
  );
  sbs_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_therm_sync
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({i_thermal_recovered, i_thermal_warning}),
    .o_sync(therm_s)
  );

  // Previous rail flags for edge detection
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      rail_prev_r <= `SBS_RST_RAIL;
    else
      rail_prev_r <= rail_s;
  end

  // Flag set events, one bit per rail flag
  assign rise = rail_s & ~rail_prev_r;

  // Sticky source bits: written ones clear, a rise in the same cycle wins
  always_comb
  begin
    src_nxt = src_r;
    if (is_src_wr(i_req))
      src_nxt = src_nxt & ~i_req.wdata;
    src_nxt = src_nxt | rise;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      src_r <= `SBS_RST_SUPPLY_IRQ;
    else
      src_r <= src_nxt;
  end

  // Summary flag follows any pending supply source bit
  assign o_supply_summary = |src_r;

  // Read multiplexer
  always_comb
  begin
    rdata_nxt = 8'h00;
    unique case (i_req.addr)
      `SBS_ADDR_SUPPLY_IRQ: rdata_nxt = src_r;
      `SBS_ADDR_BUS_FAULT: rdata_nxt = bus_s;
      `SBS_ADDR_THERMAL: rdata_nxt = {6'h00, therm_s};
      `SBS_ADDR_RAIL: rdata_nxt = rail_s;
      `SBS_ADDR_SUMMARY: rdata_nxt = {5'h00, |src_r, 2'h0};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Registered read data, one cycle after the request
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_req.rd;
      if (i_req.rd)
        o_rdata <= rdata_nxt;
    end
  end

  // Checks
  sequence seq_rail_rise(int b);
    rail_s[b] && !rail_prev_r[b];
  endsequence

  AST_LDO3_PG: assert property (@(posedge i_clock) disable iff (i_rst) seq_rail_rise(7) |=> src_r[7])
    else $error("ldo3 power good not latched");
  AST_LDO3_UV: assert property (@(posedge i_clock) disable iff (i_rst) seq_rail_rise(6) |=> src_r[6])
    else $error("ldo3 undervoltage not latched");
  AST_LDO2: assert property (@(posedge i_clock) disable iff (i_rst)
    (seq_rail_rise(5) or seq_rail_rise(4)) |=> (src_r[5] || !$past(rise[5])) && (src_r[4] || !$past(rise[4])))
    else $error("ldo2 event not latched");
  AST_FIVE_VOLT: assert property (@(posedge i_clock) disable iff (i_rst)
    rise[3:2] != 2'h0 |=> (src_r[3:2] & $past(rise[3:2])) == $past(rise[3:2]))
    else $error("5v event not latched");
  AST_BATTERY: assert property (@(posedge i_clock) disable iff (i_rst)
    rise[1:0] != 2'h0 |=> (src_r[1:0] & $past(rise[1:0])) == $past(rise[1:0]))
    else $error("battery event not latched");
  AST_BUS_READ: assert property (@(posedge i_clock) disable iff (i_rst)
    i_req.rd && i_req.addr == `SBS_ADDR_BUS_FAULT |=> o_rvalid && o_rdata == $past(bus_s))
    else $error("bus status read mismatch");
  AST_THERM_READ: assert property (@(posedge i_clock) disable iff (i_rst)
    i_req.rd && i_req.addr == `SBS_ADDR_THERMAL |=> o_rdata[7:2] == 6'h00 && o_rdata[1:0] == $past(therm_s))
    else $error("thermal status read mismatch");
  AST_SUMMARY: assert property (@(posedge i_clock) disable iff (i_rst) o_supply_summary == (src_r != 8'h00))
    else $error("summary flag mismatch");
  AST_RAIL_READ: assert property (@(posedge i_clock) disable iff (i_rst)
    i_req.rd && i_req.addr == `SBS_ADDR_RAIL |=> o_rdata == $past(rail_s))
    else $error("rail status read mismatch");
  AST_STICKY: assert property (@(posedge i_clock) disable iff (i_rst)
    src_r[0] && !is_src_wr(i_req) |=> src_r[0])
    else $error("source bit dropped without write");
  AST_CLEAR: assert property (@(posedge i_clock) disable iff (i_rst)
    is_src_wr(i_req) && i_req.wdata[7] && !rise[7] |=> !src_r[7])
    else $error("source bit not cleared");

  // Addresses that answer with register contents
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `SBS_ADDR_SUPPLY_IRQ) || (a == `SBS_ADDR_BUS_FAULT) || (a == `SBS_ADDR_THERMAL) ||
      (a == `SBS_ADDR_RAIL) || (a == `SBS_ADDR_SUMMARY);
  endfunction

  // A read request for one address, taken at this edge
  sequence seq_read(logic [7:0] a);
    i_req.rd && (i_req.addr == a);
  endsequence

  // A write to the source register that clears at least one bit
  sequence seq_src_clear;
    is_src_wr(i_req) && (i_req.wdata != 8'h00);
  endsequence

  // No flag rose in this cycle
  sequence seq_quiet;
    rise == 8'h00;
  endsequence

  // Read answer pulse follows every read request
  AST_RVALID_SET: assert property (@(posedge i_clock) disable iff (i_rst)
    i_req.rd
    |=> o_rvalid)
    else $error("read answer missing");

  // No answer pulse without a read request
  AST_RVALID_IDLE: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_req.rd
    |=> !o_rvalid)
    else $error("read answer without request");

  // Read data holds between reads
  AST_RDATA_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_req.rd
    |=> $stable(o_rdata))
    else $error("read data changed without read");

  // Source register read returns the latched bits
  AST_SRC_READ: assert property (@(posedge i_clock) disable iff (i_rst)
    seq_read(`SBS_ADDR_SUPPLY_IRQ)
    |=> o_rdata == $past(src_r))
    else $error("source read mismatch");

  // Read and write together: the read sees the value before the write
  AST_READ_PRE_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
    seq_read(`SBS_ADDR_SUPPLY_IRQ) ##0 is_src_wr(i_req)
    |=> o_rdata == $past(src_r))
    else $error("combined read saw written value");

  // Reserved slot reads zero
  AST_RSVD_READ: assert property (@(posedge i_clock) disable iff (i_rst)
    seq_read(`SBS_ADDR_RESERVED)
    |=> o_rdata == 8'h00)
    else $error("reserved slot not zero");

  // Unmapped addresses read zero
  AST_UNMAPPED_READ: assert property (@(posedge i_clock) disable iff (i_rst)
    i_req.rd && !is_mapped(i_req.addr)
    |=> o_rdata == 8'h00)
    else $error("unmapped address not zero");

  // Summary register shows the supply bit only
  AST_SUMMARY_READ: assert property (@(posedge i_clock) disable iff (i_rst)
    seq_read(`SBS_ADDR_SUMMARY)
    |=> o_rdata == {5'h00, $past(src_r) != 8'h00, 2'h0})
    else $error("summary read mismatch");

  // Any flag rise raises the summary flag
  AST_SUMMARY_EVENT: assert property (@(posedge i_clock) disable iff (i_rst)
    rise != 8'h00
    |=> o_supply_summary)
    else $error("summary missed an event");

  // Writes elsewhere leave the source bits alone
  AST_OTHER_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
    i_req.wr && (i_req.addr != `SBS_ADDR_SUPPLY_IRQ) ##0 seq_quiet
    |=> $stable(src_r))
    else $error("foreign write touched source bits");

  // Source bits set only on a flag rise
  AST_NO_SPURIOUS: assert property (@(posedge i_clock) disable iff (i_rst)
    seq_quiet
    |=> (src_r & ~$past(src_r)) == 8'h00)
    else $error("source bit set without event");

  // A quiet clearing write removes every written bit
  AST_CLEAR_SEQ: assert property (@(posedge i_clock) disable iff (i_rst)
    seq_src_clear ##0 seq_quiet
    |=> (src_r & $past(i_req.wdata)) == 8'h00)
    else $error("written bits not cleared");

  // Reset puts every register back to its start value
  AST_RESET: assert property (@(posedge i_clock)
    i_rst
    |=> src_r == `SBS_RST_SUPPLY_IRQ && !o_rvalid && o_rdata == 8'h00 && rail_prev_r == `SBS_RST_RAIL)
    else $error("reset state wrong");

  // Per-bit checks of the sticky source bits
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++)
    begin : g_src_chk
      // A rise sets the bit even against a clearing write
      AST_SET_WINS: assert property (@(posedge i_clock) disable iff (i_rst)
        rise[gb]
        |=> src_r[gb])
        else $error("source set lost");

      // A written one clears the bit when no rise competes
      AST_BIT_CLEAR: assert property (@(posedge i_clock) disable iff (i_rst)
        is_src_wr(i_req) && i_req.wdata[gb] && !rise[gb]
        |=> !src_r[gb])
        else $error("source bit not cleared");

      // A set bit stays set until a written one clears it
      AST_BIT_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
        src_r[gb] && !(is_src_wr(i_req) && i_req.wdata[gb])
        |=> src_r[gb])
        else $error("source bit dropped");
    end
  endgenerate
endmodule

// ===== verilog/sbs_defs.svh
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH
// Register offsets
`define SBS_ADDR_SUPPLY_IRQ 8'h0a
`define SBS_ADDR_RESERVED 8'h0b
`define SBS_ADDR_BUS_FAULT 8'h0c
`define SBS_ADDR_THERMAL 8'h0d
`define SBS_ADDR_RAIL 8'h0e
`define SBS_ADDR_SUMMARY 8'h07
// Reset values
`define SBS_RST_SUPPLY_IRQ 8'h00
`define SBS_RST_BUS_FAULT 8'h00
`define SBS_RST_THERMAL 8'h00
`define SBS_RST_RAIL 8'haa
// Field positions
`define SBS_SUMMARY_SUPPLY_BIT 2
`define SBS_THERMAL_RECOVER_BIT 1
`define SBS_THERMAL_WARN_BIT 0
`define SBS_THERMAL_RECOVER_DEG 140
`define SBS_THERMAL_WARN_DEG 160
`endif

// ===== verilog/sbs_pkg.sv
package sbs_pkg;
  // Rail monitor flags, order matches register bits 7 down to 0
  typedef struct packed {
    logic ldo3_power_good;
    logic ldo3_undervoltage;
    logic ldo2_power_good;
    logic ldo2_undervoltage;
    logic five_volt_power_good;
    logic five_volt_undervoltage;
    logic battery_power_good;
    logic battery_undervoltage;
  } sbs_rail_s;
  // Bus fault monitor flags, bits 7 down to 0
  typedef struct packed {
    logic bus_held_dominant;
    logic txd_rxd_short;
    logic rxd_stuck_recessive;
    logic txd_stuck_dominant;
    logic bus_low_line_to_supply;
    logic bus_low_line_to_ground;
    logic bus_high_line_to_ground;
    logic bus_high_line_to_supply;
  } sbs_bus_s;
  // Register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sbs_req_s;
endpackage

// ===== verilog/sbs_sync.sv
`timescale 1ns/1ps
`include "sbs_defs.svh"
// Three-stage synchroniser, change accepted when stages two and three agree
module sbs_sync
  import sbs_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // Shift chain
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end
    else
    begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Per-bit agreement filter
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge i_clock)
      begin
        if (i_rst)
          o_sync[g] <= RESET_VAL[g];
        else if (s2_r[g] == s3_r[g])
          o_sync[g] <= s3_r[g];
      end
    end
  endgenerate
endmodule

// ===== verif/sbs_host.sv
`timescale 1ns/1ps
// Host model: single-cycle register requests launched on the falling edge
module sbs_host
  import sbs_pkg::*;
(
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output sbs_req_s o_req
);
  initial o_req = '0;
  // Write one byte; ones clear latched source bits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge i_clock);
    o_req = '0;
  endtask
  // Read one byte, bounded wait for the answer pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge i_clock);
    o_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge i_clock);
    o_req = '0;
    n = 0;
    while (i_rvalid !== 1'b1 && n < 3)
    begin
      @(negedge i_clock);
      n++;
    end
    d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
  endtask
endmodule

// ===== verif/test_sbs_regs.sv
`timescale 1ns/1ps
`include "sbs_defs.svh"
module test_sbs_regs
  import sbs_pkg::*;
;
  logic i_clock;
  logic i_rst;
  sbs_rail_s rail;
  sbs_bus_s bus;
  logic rec;
  logic warn;
  sbs_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic summary;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  sbs_regs i_dut(.i_clock(i_clock), .i_rst(i_rst), .i_rail(rail), .i_bus(bus), .i_thermal_recovered(rec),
    .i_thermal_warning(warn), .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid), .o_supply_summary(summary));
  sbs_host i_host(.i_clock(i_clock), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

  // Clock generation
  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  // Hang guard
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Read and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    check(d, exp);
  endtask

  // Let the input synchronisers settle
  task automatic settle();
    repeat (6) @(negedge i_clock);
  endtask

  task automatic t_reset();
    rchk(`SBS_ADDR_SUPPLY_IRQ, `SBS_RST_SUPPLY_IRQ);
    rchk(`SBS_ADDR_RESERVED, 8'h00);
    rchk(`SBS_ADDR_BUS_FAULT, `SBS_RST_BUS_FAULT);
    rchk(`SBS_ADDR_THERMAL, `SBS_RST_THERMAL);
    rchk(`SBS_ADDR_RAIL, `SBS_RST_RAIL);
    check({7'h00, summary}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_latch();
    rail = 8'h55;
    settle();
    rchk(`SBS_ADDR_RAIL, 8'h55);
    rchk(`SBS_ADDR_SUPPLY_IRQ, 8'h55);
    check({7'h00, summary}, 8'h01);
    rail = 8'haa;
    settle();
    rchk(`SBS_ADDR_SUPPLY_IRQ, 8'hff);
    rail = 8'h00;
    settle();
    rchk(`SBS_ADDR_SUPPLY_IRQ, 8'hff);
    i_host.wr(`SBS_ADDR_SUPPLY_IRQ, 8'h0f);
    rchk(`SBS_ADDR_SUPPLY_IRQ, 8'hf0);
    check({7'h00, summary}, 8'h01);
    i_host.wr(`SBS_ADDR_RAIL, 8'hff);
    rchk(`SBS_ADDR_RAIL, 8'h00);
    i_host.wr(`SBS_ADDR_SUPPLY_IRQ, 8'hf0);
    rchk(`SBS_ADDR_SUPPLY_IRQ, 8'h00);
    check({7'h00, summary}, 8'h00);
    $display("test latch done");
  endtask

  task automatic t_bus();
    for (int i = 0; i < 8; i++)
    begin
      bus = 8'h01 << i;
      settle();
      rchk(`SBS_ADDR_BUS_FAULT, 8'h01 << i);
    end
    $display("test bus done");
  endtask

  task automatic t_therm();
    for (int i = 0; i < 4; i++)
    begin
      rec = i[1];
      warn = i[0];
      settle();
      rchk(`SBS_ADDR_THERMAL, 8'(i));
    end
    $display("test thermal done");
  endtask

  // Summary register, answer pulse width, read data hold, set winning over clear
  task automatic t_extra();
    rail = 8'h01;
    settle();
    rchk(`SBS_ADDR_SUMMARY, 8'h04);
    @(negedge i_clock);
    check({7'h00, rvalid}, 8'h00);
    check(rdata, 8'h04);
    check({7'h00, summary}, 8'h01);
    rchk(`SBS_ADDR_SUPPLY_IRQ, 8'h01);
    i_host.wr(`SBS_ADDR_SUPPLY_IRQ, 8'hff);
    rail = 8'h03;
    repeat (3) @(negedge i_clock);
    i_host.wr(`SBS_ADDR_SUPPLY_IRQ, 8'h02);
    rchk(`SBS_ADDR_SUPPLY_IRQ, 8'h02);
    $display("test extra done");
  endtask

  // Main sequence
  initial
  begin
    i_rst = 1'b1;
    rail = 8'haa;
    bus = 8'h00;
    rec = 1'b0;
    warn = 1'b0;
    repeat (8) @(negedge i_clock);
    i_rst = 1'b0;
    t_reset();
    t_latch();
    t_bus();
    t_therm();
    t_extra();
    end_of_test();
  end
endmodule
